/* File: rtl/secu_pkg.sv */
// package of constants for the serial eeprom command unit
// assumes a 200 MHz system clock and a three-wire serial eeprom
//
// Summary of operation
// - registers not reachable while ce is low
// - busy write starts opcode at address
// - read done means data register valid
// - busy high during load after reset
// - three-bit opcode decode, resets zero
// - read places addressed byte in data
// - write stores data byte at address
// - write-all stores data everywhere
// - erase clears addressed location
// - erase-all bulk erases whole part
// - reload checks A5h signature first
// - failed reload changes nothing
// - 30 ms no response gives timeout
// - absent part write waits for timeout when the input is pulled low
// - serial input high never times out
// - input low: only erase/write ops time out
// - loaded flag set on success, write-one clears
// - nine-bit byte address field
package secu_pkg;
  localparam logic [15:0] CMD_OFFSET     = 16'h6000;
  localparam logic [15:0] DATA_OFFSET    = 16'h6004;
  localparam int          BUSY_BIT       = 31;
  localparam int          OP_HI          = 30;
  localparam int          OP_LO          = 28;
  localparam int          TIMEOUT_BIT    = 10;
  localparam int          LOADED_BIT     = 9;
  localparam int          ADDR_W         = 9;
  localparam logic [2:0]  OP_READ        = 3'h0;
  localparam logic [2:0]  OP_DISABLE     = 3'h1;
  localparam logic [2:0]  OP_ENABLE      = 3'h2;
  localparam logic [2:0]  OP_WRITE       = 3'h3;
  localparam logic [2:0]  OP_WRITE_ALL   = 3'h4;
  localparam logic [2:0]  OP_ERASE       = 3'h5;
  localparam logic [2:0]  OP_ERASE_ALL   = 3'h6;
  localparam logic [2:0]  OP_RELOAD      = 3'h7;
  localparam logic [7:0]  SIGNATURE      = 8'hA5;
  localparam int          CLK_MHZ        = 200;
  localparam int          TIMEOUT_MS     = 30;
  localparam int          TIMEOUT_CYC    = TIMEOUT_MS * 1000 * CLK_MHZ;
  localparam int          SCLK_HALF_CYC  = 50;
  localparam int          RELOAD_BYTES   = 8;
endpackage

/* File: rtl/secu_shadow_mem.sv */
// small memory holding configuration bytes fetched during a load
// assumes single clock; read data registered
`timescale 1ns/1ps
module secu_shadow_mem #(
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  input  wire logic          clk,
  input  wire logic          ce,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [7:0]    wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [7:0]    rdata
);
  logic [7:0] mem_reg [DEPTH];

  always_ff @(posedge clk) begin
    if (ce && we) begin
      mem_reg[waddr] <= wdata;
    end
    if (ce) begin
      rdata <= mem_reg[raddr];
    end
  end
endmodule

/* File: rtl/secu_top.sv */
// serial eeprom command unit: register slave plus 3-wire eeprom sequencer
// assumes host bus on clk; eeprom serial input is a pin, synchronised here
`timescale 1ns/1ps
module secu_top #(
  parameter int TIMEOUT_CYCLES = secu_pkg::TIMEOUT_CYC,
  parameter int HALF_CYCLES    = secu_pkg::SCLK_HALF_CYC,
  parameter int LOAD_BYTES     = secu_pkg::RELOAD_BYTES
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        ce,
  input  wire logic        usb_reset,
  input  wire logic [15:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output logic      [31:0] rdata,
  output logic             eeprom_cs,
  output logic             eeprom_sclk,
  output logic             eeprom_do,
  input  wire logic        eeprom_serial_in,
  output logic      [2:0]  shadow_raddr_unused_q,
  input  wire logic [2:0]  shadow_raddr,
  output logic      [7:0]  shadow_rdata
);
  // ------------------------------------------------------------
  // types and state
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    SECU_IDLE  = 3'b000,
    SECU_SHIFT = 3'b001,
    SECU_READ  = 3'b010,
    SECU_GAP   = 3'b011,
    SECU_POLL  = 3'b100,
    SECU_DONE  = 3'b101
  } secu_state_t;

  secu_state_t     state_reg;
  logic            op_busy_flag_reg;
  logic [2:0]      eeprom_opcode_reg;
  logic [8:0]      eeprom_byte_pointer_reg;
  logic            no_response_flag_reg;
  logic            contents_loaded_flag_reg;
  logic [7:0]      eeprom_data_byte_reg;
  logic [5:0]      bits_left_reg;
  logic [7:0]      rx_reg;
  logic [31:0]     div_reg;
  logic [31:0]     tmo_reg;
  logic            sclk_reg;
  logic            cs_reg;
  logic            is_load_reg;
  logic [3:0]      load_idx_reg;
  logic [31:0]     rdata_reg;
  logic [2:0]      sync_reg;
  logic            din;
  logic [19:0]     frame;
  logic [5:0]      frame_len;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  function automatic logic is_erase_write(input logic [2:0] op);
    is_erase_write = (op == secu_pkg::OP_WRITE) || (op == secu_pkg::OP_WRITE_ALL) ||
                     (op == secu_pkg::OP_ERASE) || (op == secu_pkg::OP_ERASE_ALL);
  endfunction

  wire        hit_cmd   = addr == secu_pkg::CMD_OFFSET;
  wire        hit_data  = addr == secu_pkg::DATA_OFFSET;
  wire        wr_cmd    = ce && wr_stb && hit_cmd;
  wire        wr_data   = ce && wr_stb && hit_data && !op_busy_flag_reg;
  wire        start_cmd = wr_cmd && wdata[secu_pkg::BUSY_BIT] && !op_busy_flag_reg;
  wire [2:0]  new_op    = wdata[secu_pkg::OP_HI:secu_pkg::OP_LO];
  wire        half_tick = div_reg == 32'(HALF_CYCLES - 1);
  wire        fall_edge = half_tick && sclk_reg;
  wire        rise_edge = half_tick && !sclk_reg;
  wire        timed_out = tmo_reg == 32'(TIMEOUT_CYCLES - 1);
  wire        in_load   = is_load_reg;
  wire [8:0]  eff_addr  = in_load ? 9'(load_idx_reg) : eeprom_byte_pointer_reg;

  // frame: start bit, 2-bit code, address, data
  always_comb begin
    frame     = 20'h00000;
    frame_len = 6'h0C;
    case (in_load ? secu_pkg::OP_READ : eeprom_opcode_reg)
      secu_pkg::OP_READ:      frame = {1'b1, 2'b10, eff_addr, 8'h00};
      secu_pkg::OP_DISABLE:   frame = {1'b1, 2'b00, 2'b00, 7'h00, 8'h00};
      secu_pkg::OP_ENABLE:    frame = {1'b1, 2'b00, 2'b11, 7'h00, 8'h00};
      secu_pkg::OP_WRITE:     frame = {1'b1, 2'b01, eff_addr, eeprom_data_byte_reg};
      secu_pkg::OP_WRITE_ALL: frame = {1'b1, 2'b00, 2'b01, 7'h00, eeprom_data_byte_reg};
      secu_pkg::OP_ERASE:     frame = {1'b1, 2'b11, eff_addr, 8'h00};
      secu_pkg::OP_ERASE_ALL: frame = {1'b1, 2'b00, 2'b10, 7'h00, 8'h00};
      default:                frame = {1'b1, 2'b10, eff_addr, 8'h00};
    endcase
    if ((!in_load) && ((eeprom_opcode_reg == secu_pkg::OP_WRITE) ||
        (eeprom_opcode_reg == secu_pkg::OP_WRITE_ALL))) begin
      frame_len = 6'h14;
    end
  end

  // ------------------------------------------------------------
  // pin synchroniser: change counts once stages two and three agree
  // ------------------------------------------------------------
  logic din_reg;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_reg <= 3'h7;
      din_reg  <= 1'b1;
    end else if (ce) begin
      sync_reg <= {sync_reg[1:0], eeprom_serial_in};
      if (sync_reg[2] == sync_reg[1]) begin
        din_reg <= sync_reg[2];
      end
    end
  end
  assign din = din_reg;

  // ------------------------------------------------------------
  // register slave: the bus runs on clk, and only while ce is high
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_reg <= 32'h00000000;
    end else if (ce) begin
      rdata_reg <= 32'h00000000;
      if (rd_stb && hit_cmd) begin
        rdata_reg <= {op_busy_flag_reg, eeprom_opcode_reg, 17'h00000,
                      no_response_flag_reg, contents_loaded_flag_reg,
                      eeprom_byte_pointer_reg};
      end else if (rd_stb && hit_data) begin
        rdata_reg <= {24'h000000, eeprom_data_byte_reg};
      end
    end
  end
  assign rdata = rdata_reg;

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  logic shadow_we;
  assign shadow_we = ce && in_load && (state_reg == SECU_READ) && rise_edge &&
                     (bits_left_reg == 6'h01) && (load_idx_reg != 4'h0);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg                <= SECU_IDLE;
      op_busy_flag_reg         <= 1'b1;  // load after reset
      is_load_reg              <= 1'b1;
      eeprom_opcode_reg        <= secu_pkg::OP_READ;
      eeprom_byte_pointer_reg  <= 9'h000;
      no_response_flag_reg     <= 1'b0;
      contents_loaded_flag_reg <= 1'b0;
      eeprom_data_byte_reg     <= 8'h00;
      bits_left_reg            <= 6'h00;
      rx_reg                   <= 8'h00;
      div_reg                  <= 32'h0;
      tmo_reg                  <= 32'h0;
      sclk_reg                 <= 1'b0;
      cs_reg                   <= 1'b0;
      load_idx_reg             <= 4'h0;
    end else if (ce) begin
      div_reg <= half_tick ? 32'h0 : div_reg + 32'h1;
      if (wr_cmd && !op_busy_flag_reg) begin
        eeprom_opcode_reg       <= new_op;
        eeprom_byte_pointer_reg <= wdata[secu_pkg::ADDR_W-1:0];
      end
      if (wr_cmd && wdata[secu_pkg::LOADED_BIT]) begin
        contents_loaded_flag_reg <= 1'b0;
      end
      if (wr_data) begin
        eeprom_data_byte_reg <= wdata[7:0];
      end
      if (usb_reset) begin
        op_busy_flag_reg <= 1'b1;
        is_load_reg      <= 1'b1;
        no_response_flag_reg <= 1'b0;
        load_idx_reg     <= 4'h0;
        state_reg        <= SECU_IDLE;
        cs_reg           <= 1'b0;
        sclk_reg         <= 1'b0;
      end else begin
        case (state_reg)
          SECU_IDLE: begin
            if (start_cmd || op_busy_flag_reg) begin
              if (start_cmd) begin
                op_busy_flag_reg     <= 1'b1;
                no_response_flag_reg <= 1'b0;
                is_load_reg          <= (new_op == secu_pkg::OP_RELOAD);
                load_idx_reg         <= 4'h0;
              end
              cs_reg        <= 1'b1;
              bits_left_reg <= 6'h00;
              state_reg     <= SECU_SHIFT;
            end
          end
          SECU_SHIFT: begin
            if (fall_edge || (bits_left_reg == 6'h00 && half_tick)) begin
              if (bits_left_reg == 6'h00) begin
                bits_left_reg <= frame_len;
              end else if (bits_left_reg == 6'h01) begin
                if (in_load || eeprom_opcode_reg == secu_pkg::OP_READ) begin
                  bits_left_reg <= 6'h08;
                  state_reg     <= SECU_READ;
                end else begin
                  state_reg <= SECU_GAP;
                end
              end else begin
                bits_left_reg <= bits_left_reg - 6'h01;
              end
            end
            if (half_tick && bits_left_reg != 6'h00) begin
              sclk_reg <= !sclk_reg;
            end
          end
          SECU_READ: begin
            if (half_tick) begin
              sclk_reg <= !sclk_reg;
            end
            if (rise_edge) begin
              rx_reg        <= {rx_reg[6:0], din};
              bits_left_reg <= bits_left_reg - 6'h01;
              if (bits_left_reg == 6'h01) begin
                state_reg <= SECU_DONE;
              end
            end
          end
          SECU_GAP: begin
            sclk_reg <= 1'b0;
            cs_reg   <= 1'b0;
            tmo_reg  <= 32'h0;
            state_reg <= is_erase_write(eeprom_opcode_reg) ? SECU_POLL : SECU_DONE;
          end
          SECU_POLL: begin
            // ready/busy poll: erase and write ops wait on the serial input
            cs_reg  <= 1'b1;
            tmo_reg <= tmo_reg + 32'h1;
            if (din) begin
              state_reg <= SECU_DONE;
            end else if (timed_out) begin
              no_response_flag_reg <= 1'b1;
              op_busy_flag_reg     <= 1'b0;
              cs_reg               <= 1'b0;
              state_reg            <= SECU_IDLE;
            end
          end
          SECU_DONE: begin
            cs_reg   <= 1'b0;
            sclk_reg <= 1'b0;
            if (in_load) begin
              if (load_idx_reg == 4'h0 && rx_reg != secu_pkg::SIGNATURE) begin
                // unprogrammed part: leave everything as it was
                is_load_reg      <= 1'b0;
                op_busy_flag_reg <= 1'b0;
                state_reg        <= SECU_IDLE;
              end else if (load_idx_reg == 4'(LOAD_BYTES - 1)) begin
                contents_loaded_flag_reg <= 1'b1;
                is_load_reg              <= 1'b0;
                op_busy_flag_reg         <= 1'b0;
                state_reg                <= SECU_IDLE;
              end else begin
                load_idx_reg <= load_idx_reg + 4'h1;
                state_reg    <= SECU_IDLE;
              end
            end else begin
              if (eeprom_opcode_reg == secu_pkg::OP_READ) begin
                eeprom_data_byte_reg <= rx_reg;  // same edge as busy clear
              end
              op_busy_flag_reg <= 1'b0;
              state_reg        <= SECU_IDLE;
            end
          end
          default: state_reg <= SECU_IDLE;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // pins and shadow store
  // ------------------------------------------------------------
  assign eeprom_cs   = cs_reg;
  assign eeprom_sclk = sclk_reg;
  // short frames sit in the top twelve bits, so count down from the frame's msb
  wire [4:0] frame_bit = 5'(bits_left_reg + 6'h13 - frame_len);
  assign eeprom_do   = (state_reg == SECU_SHIFT && bits_left_reg != 6'h00) ?
                       frame[frame_bit] : 1'b0;
  assign shadow_raddr_unused_q = shadow_raddr;

  secu_shadow_mem #(
    .DEPTH (8),
    .AW    (3)
  ) u_mem (
    .clk   (clk),
    .ce    (ce),
    .we    (shadow_we),
    .waddr (load_idx_reg[2:0]),
    .wdata ({rx_reg[6:0], din}),
    .raddr (shadow_raddr),
    .rdata (shadow_rdata)
  );

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_start;
    ce && start_cmd;
  endsequence

  sequence s_host_reset;
    ce && usb_reset;
  endsequence

  sequence s_bad_signature;
    ce && state_reg == SECU_DONE && in_load && !usb_reset && !wr_cmd &&
      load_idx_reg == 4'h0 && rx_reg != secu_pkg::SIGNATURE;
  endsequence

  a_busy_on_start: assert property (@(posedge clk) disable iff (!reset_n)
    s_start |=> op_busy_flag_reg && !no_response_flag_reg)
    else $error("busy not set on start");
  a_timeout_clears: assert property (@(posedge clk) disable iff (!reset_n)
    (ce && state_reg == SECU_POLL && timed_out && !din && !usb_reset)
      |=> !op_busy_flag_reg && no_response_flag_reg)
    else $error("timeout did not end op");
  a_read_data_valid: assert property (@(posedge clk) disable iff (!reset_n)
    (ce && state_reg == SECU_DONE && !in_load && !usb_reset &&
     eeprom_opcode_reg == secu_pkg::OP_READ)
      |=> eeprom_data_byte_reg == $past(rx_reg))
    else $error("read data not captured");
  a_loaded_sig_ok: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(contents_loaded_flag_reg) |-> $past(is_load_reg))
    else $error("loaded set outside load");
  a_poll_only_ew: assert property (@(posedge clk) disable iff (!reset_n)
    state_reg == SECU_POLL |-> is_erase_write(eeprom_opcode_reg))
    else $error("poll on non erase op");
  a_usb_reset_load: assert property (@(posedge clk) disable iff (!reset_n)
    s_host_reset |=> op_busy_flag_reg && in_load)
    else $error("usb reset did not restart load");
  a_bad_sig_keeps: assert property (@(posedge clk) disable iff (!reset_n)
    s_bad_signature |=> !op_busy_flag_reg && !in_load && !no_response_flag_reg &&
      contents_loaded_flag_reg == $past(contents_loaded_flag_reg))
    else $error("failed reload changed state");
  a_start_bit_first: assert property (@(posedge clk) disable iff (!reset_n)
    (ce && state_reg == SECU_SHIFT && bits_left_reg == frame_len) |-> eeprom_do)
    else $error("frame does not open with start bit");
endmodule

/* File: sim/secu_eeprom_model.sv */
// behavioural 512-byte serial eeprom facing the command unit
// assumes frames: start bit, 2-bit code, 9-bit address, 8 data bits
`timescale 1ns/1ps
module secu_eeprom_model (
  input  wire logic clk,
  input  wire logic eeprom_cs,
  input  wire logic eeprom_sclk,
  input  wire logic eeprom_do,
  input  wire logic present,
  input  wire logic pull_hi,
  output logic      eeprom_serial_in
);
  // ----------------------------------------
  // storage and frame decode
  // ----------------------------------------
  logic [7:0]  mem [512];
  logic        wr_ok = 1'b0; // powers up write disabled
  logic        started, rd_on, poll, drv;
  logic [18:0] sh;
  logic [7:0]  dout;
  logic [1:0]  code;
  logic [8:0]  a;
  int          nb;
  int          busy = 0;
  initial begin
    for (int i = 0; i < 512; i++) mem[i] = i[7:0];
    mem[0] = 8'hA5;
    {started, rd_on, poll, drv, nb} = '0;
  end
  always @(posedge eeprom_cs) begin
    started = 1'b0;
    nb = 0;
    rd_on = 1'b0;
  end
  // commit on the last bit, so a cs held high into polling still works
  always @(posedge eeprom_sclk) if (eeprom_cs) begin
    if (!started) started = eeprom_do;
    else begin
      sh = {sh[17:0], eeprom_do};
      nb++;
      code = (nb == 19) ? sh[18:17] : sh[10:9];
      a = (nb == 19) ? sh[16:8] : sh[8:0];
      if (nb == 11 && code == 2'h2) begin
        rd_on = 1'b1;
        dout = mem[a];
      end else if (nb == 11 && code == 2'h0 && a[8:7] == 2'h0) wr_ok = 1'b0;
      else if (nb == 11 && code == 2'h0 && a[8:7] == 2'h3) wr_ok = 1'b1;
      // read frames run past bit 11 while data comes back, so they never commit
      else if (wr_ok && !rd_on && (nb == 19 || (nb == 11 &&
               (code == 2'h3 || (code == 2'h0 && a[8:7] == 2'h2))))) begin
        busy = 20;
        poll = 1'b1;
        for (int i = 0; i < 512; i++)
          if (code == 2'h0 && a[8:7] == 2'h2) mem[i] = 8'hFF;
          else if (nb == 19 && code == 2'h0) mem[i] = sh[7:0];
        if (code == 2'h3) mem[a] = 8'hFF;
        if (code == 2'h1) mem[a] = sh[7:0];
      end
    end
  end
  always @(negedge eeprom_sclk) if (rd_on) begin
    drv = dout[7];
    dout = {dout[6:0], 1'b0};
  end
  always @(negedge eeprom_cs) begin
    rd_on = 1'b0;
    if (busy == 0) poll = 1'b0;
  end
  always @(posedge clk) if (busy > 0) busy--;
  // a released line falls to the pull level
  assign eeprom_serial_in = (present && eeprom_cs && (rd_on || poll)) ?
                            (rd_on ? drv : (busy == 0)) : pull_hi;
endmodule

/* File: sim/testbench.sv */
// self-checking bench for the serial eeprom command unit
// assumes the eeprom model on the serial pins, short timeout parameter
`timescale 1ns/1ps
module testbench;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  localparam int TMO = 400;
  logic        clk, reset_n, usb_reset, wr_stb, rd_stb, present, pull_hi, ce;
  logic [15:0] addr;
  logic [31:0] wdata, rdata, v;
  logic        cs, sclk, sdo, sdi;
  logic [2:0]  shadow_raddr, echo_q;
  logic [7:0]  shadow_rdata;
  int          error_cnt = 0;
  int          check_count = 0;
  int          n;
  secu_top #(.TIMEOUT_CYCLES(TMO), .HALF_CYCLES(8), .LOAD_BYTES(8)) dut_u (
    .clk(clk), .reset_n(reset_n), .ce(ce), .usb_reset(usb_reset), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .eeprom_cs(cs), .eeprom_sclk(sclk), .eeprom_do(sdo), .eeprom_serial_in(sdi),
    .shadow_raddr_unused_q(echo_q), .shadow_raddr(shadow_raddr), .shadow_rdata(shadow_rdata));
  secu_eeprom_model mdl_u (.clk(clk), .eeprom_cs(cs), .eeprom_sclk(sclk),
    .eeprom_do(sdo), .present(present), .pull_hi(pull_hi), .eeprom_serial_in(sdi));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ----------------------------------------
  // bus tasks and checks
  // ----------------------------------------
  task automatic conclude();
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask
  // polls busy; n returns the number of polls that saw busy set
  task automatic idle();
    for (n = 0; n < 3000; n++) begin
      rd(16'h6000, v);
      if (v[31] === 1'b0) return;
    end
    chk("busy wait", 32'h0, 32'h1);
    conclude();
  endtask
  task automatic op(input logic [2:0] o, input logic [8:0] a);
    wr(16'h6000, {1'b1, o, 19'h0, a});
    idle();
  endtask
  task automatic rd_byte(input logic [8:0] a, input logic [7:0] e);
    op(secu_pkg::OP_READ, a);
    rd(16'h6004, v);
    chk("read byte", {24'h0, e}, v & 32'h0000_00FF);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic s_reset();
    rd(16'h6000, v);
    chk("busy at reset", 32'h1, {31'h0, v[31]});
    chk("cmd fields", 32'h0, v & 32'h7000_01FF);
    idle();
    chk("loaded", 32'h1, {31'h0, v[secu_pkg::LOADED_BIT]});
    shadow_raddr <= 3'h1;
    repeat (3) @(posedge clk);
    chk("shadow byte", 32'h01, {24'h0, shadow_rdata});
    chk("raddr echo", 32'h1, {29'h0, echo_q});
    usb_reset <= 1'b1;
    @(posedge clk);
    usb_reset <= 1'b0;
    rd(16'h6000, v);
    chk("busy usb reset", 32'h1, {31'h0, v[31]});
    idle();
    rd(16'h6008, v);
    chk("unmapped", 32'h0, v);
  endtask
  task automatic s_write();
    rd_byte(9'h17F, 8'h7F);
    wr(16'h6004, 32'h3C);
    op(secu_pkg::OP_WRITE, 9'h005);
    rd_byte(9'h005, 8'h05);
    op(secu_pkg::OP_ENABLE, 9'h0);
    wr(16'h6004, 32'h3C);
    wr(16'h6000, {1'b1, secu_pkg::OP_WRITE, 19'h0, 9'h005});
    wr(16'h6004, 32'h99);
    idle();
    rd(16'h6004, v);
    chk("data kept busy", 32'h3C, v & 32'hFF);
    rd_byte(9'h005, 8'h3C);
    op(secu_pkg::OP_ERASE, 9'h005);
    rd_byte(9'h005, 8'hFF);
    op(secu_pkg::OP_DISABLE, 9'h0);
    wr(16'h6004, 32'h77);
    op(secu_pkg::OP_WRITE, 9'h005);
    rd_byte(9'h005, 8'hFF);
    ce <= 1'b0;
    wr(16'h6004, 32'hEE);
    ce <= 1'b1;
    rd(16'h6004, v);
    chk("frozen by ce", 32'hFF, v & 32'hFF);
  endtask
  task automatic s_bulk();
    op(secu_pkg::OP_ENABLE, 9'h0);
    wr(16'h6004, 32'h5A);
    op(secu_pkg::OP_WRITE_ALL, 9'h0);
    rd_byte(9'h100, 8'h5A);
    wr(16'h6000, 32'h0000_0200);
    rd(16'h6000, v);
    chk("loaded clear", 32'h0, {31'h0, v[secu_pkg::LOADED_BIT]});
    op(secu_pkg::OP_RELOAD, 9'h0);
    chk("loaded on bad sig", 32'h0, {31'h0, v[secu_pkg::LOADED_BIT]});
    chk("shadow kept", 32'h01, {24'h0, shadow_rdata});
    op(secu_pkg::OP_ERASE_ALL, 9'h0);
    rd_byte(9'h042, 8'hFF);
  endtask
  task automatic s_absent();
    present <= 1'b0;
    pull_hi <= 1'b0;
    op(secu_pkg::OP_WRITE, 9'h010);
    chk("timeout set", 32'h1, {31'h0, v[secu_pkg::TIMEOUT_BIT]});
    chk("busy long", 32'h1, {31'h0, n * 2 >= TMO});
    op(secu_pkg::OP_READ, 9'h010);
    chk("read no timeout", 32'h0, {31'h0, v[secu_pkg::TIMEOUT_BIT]});
    pull_hi <= 1'b1;
    op(secu_pkg::OP_ERASE, 9'h010);
    chk("pulled high", 32'h0, {31'h0, v[secu_pkg::TIMEOUT_BIT]});
  endtask
  initial begin
    {reset_n, usb_reset, wr_stb, rd_stb} = 4'h0;
    addr = 16'h0;
    wdata = 32'h0;
    shadow_raddr = 3'h0;
    ce = 1'b1;
    present = 1'b1;
    pull_hi = 1'b1;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    s_reset();
    s_write();
    s_bulk();
    s_absent();
    conclude();
  end
endmodule
